// file: rtl/mstc_pkg.sv
// mstc_pkg: shared constants for the microstep translator and pwm control
// assumes a 25 MHz core clock
package mstc_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ       = 25;
  localparam int T_OFF_US      = 30;
  localparam int T_BLANK_US    = 1;
  localparam int OFF_CYC       = T_OFF_US * CLK_MHZ;
  localparam int BLANK_CYC     = T_BLANK_US * CLK_MHZ;
  // fast part is 31.25 % = 5/16 of the off-time, rounded down
  localparam int FAST_NUM      = 5;
  localparam int FAST_DEN      = 16;
  localparam int FAST_CYC      = (OFF_CYC * FAST_NUM) / FAST_DEN;

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  localparam int     POS_W    = 5;
  localparam int     LVL_W    = 4;
  // home sits at 45 degrees, a point shared by every resolution
  localparam logic [4:0] HOME_POS = 5'h04;

  typedef enum logic [1:0] {
    MSTC_RES_FULL    = 2'h0,
    MSTC_RES_HALF    = 2'h1,
    MSTC_RES_QUARTER = 2'h2,
    MSTC_RES_EIGHTH  = 2'h3
  } mstc_res_e;

  typedef enum logic [1:0] {
    MSTC_DEC_SLOW  = 2'h0,
    MSTC_DEC_MIXED = 2'h1
  } mstc_decay_e;

endpackage : mstc_pkg

// file: rtl/mstc_bridge_pwm.sv
// mstc_bridge_pwm: fixed off-time pwm loop for one full-bridge
// assumes i_trip is already synchronised to i_clk
`timescale 1ns/10ps
`default_nettype none
module mstc_bridge_pwm #(
  parameter int OFF_CYC   = mstc_pkg::OFF_CYC,
  parameter int FAST_CYC  = mstc_pkg::FAST_CYC,
  parameter int BLANK_CYC = mstc_pkg::BLANK_CYC
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // control
  input  wire logic i_run,
  input  wire logic i_mixed,
  input  wire logic i_trip,
  // state
  output logic      o_drive,
  output logic      o_fast,
  output logic      o_slow
);
  // counters are 12 bits wide and the fast part must fit inside the off-time
  if (FAST_CYC < 1 || FAST_CYC >= OFF_CYC || BLANK_CYC < 1 || OFF_CYC > 4095) begin : g_bad_timing
    $error("mstc_bridge_pwm: bad timing parameters");
  end

  typedef enum logic [2:0] {
    MSTC_PH_DRIVE = 3'b001,
    MSTC_PH_FAST  = 3'b010,
    MSTC_PH_SLOW  = 3'b100
  } mstc_phase_e;

  mstc_phase_e state, next_state;
  logic [11:0] cnt, next_cnt;
  logic [11:0] blank, next_blank;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_blank = (blank != 12'h000) ? blank - 12'h001 : 12'h000;
    if (!i_run) begin
      next_state = MSTC_PH_DRIVE;
      next_blank = 12'(BLANK_CYC);
      next_cnt   = 12'h000;
    end else begin
      unique case (state)
        MSTC_PH_DRIVE: begin
          // trip ends on-time and starts the off timer; blanked first
          if (i_trip && blank == 12'h000) begin
            next_cnt   = 12'h000;
            next_blank = 12'(BLANK_CYC);
            next_state = i_mixed ? MSTC_PH_FAST : MSTC_PH_SLOW;
          end
        end
        MSTC_PH_FAST: begin
          next_cnt = cnt + 12'h001;
          if (cnt == 12'(FAST_CYC - 1)) begin
            next_state = MSTC_PH_SLOW;
            next_blank = 12'(BLANK_CYC);
          end
        end
        MSTC_PH_SLOW: begin
          next_cnt = cnt + 12'h001;
          if (cnt == 12'(OFF_CYC - 1)) begin
            next_state = MSTC_PH_DRIVE;
            next_blank = 12'(BLANK_CYC);
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= MSTC_PH_DRIVE;
      cnt   <= 12'h000;
      blank <= 12'h000;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      blank <= next_blank;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_drive <= 1'b0;
      o_fast  <= 1'b0;
      o_slow  <= 1'b0;
    end else begin
      o_drive <= i_run && next_state == MSTC_PH_DRIVE;
      o_fast  <= i_run && next_state == MSTC_PH_FAST;
      o_slow  <= i_run && next_state == MSTC_PH_SLOW;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  trip_blanked_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state == MSTC_PH_DRIVE && blank != 12'h000 && i_run) |=> state != MSTC_PH_FAST && state != MSTC_PH_SLOW)
    else $error("trip taken during blanking");
  fast_len_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_run && state == MSTC_PH_FAST && cnt == 12'(FAST_CYC - 1)) |=> state == MSTC_PH_SLOW)
    else $error("fast phase not ended at fraction");
  off_end_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_run && state == MSTC_PH_SLOW && cnt == 12'(OFF_CYC - 1)) |=> state == MSTC_PH_DRIVE)
    else $error("off-time did not end");
  slow_direct_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_run && state == MSTC_PH_DRIVE && i_trip && blank == 12'h000 && !i_mixed) |=> state == MSTC_PH_SLOW)
    else $error("slow decay not entered on trip");
  mixed_cov_c : cover property (@(posedge i_clk) disable iff (!i_rstn)
    state == MSTC_PH_FAST ##1 state == MSTC_PH_SLOW);
  slow_cov_c : cover property (@(posedge i_clk) disable iff (!i_rstn)
    state == MSTC_PH_DRIVE ##1 state == MSTC_PH_SLOW);
endmodule : mstc_bridge_pwm
`default_nettype wire

// file: rtl/mstc_top.sv
// mstc_top: step translator, decay selection and two bridge pwm loops
// assumes all control pins are asynchronous and a 25 MHz clock
`timescale 1ns/10ps
`default_nettype none
module mstc_top (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // host control pins
  input  wire logic i_step,
  input  wire logic i_dir,
  input  wire logic i_resolution_select_0,
  input  wire logic i_resolution_select_1,
  input  wire logic i_enable_n,
  input  wire logic i_off_time_set_pin,
  input  wire logic i_reset_n,
  // fault events
  input  wire logic i_thermal_shutdown_event,
  input  wire logic i_overcurrent,
  // comparators, sense_resistor_a and sense_resistor_b at trip level
  input  wire logic i_trip_a,
  input  wire logic i_trip_b,
  // bridge a
  output logic [3:0] o_level_a,
  output logic       o_pol_a,
  output logic       o_drive_a,
  output logic       o_fast_a,
  output logic       o_slow_a,
  // bridge b
  output logic [3:0] o_level_b,
  output logic       o_pol_b,
  output logic       o_drive_b,
  output logic       o_fast_b,
  output logic       o_slow_b,
  // decay choice and position
  output logic       o_mixed_a,
  output logic       o_mixed_b,
  output logic [4:0] o_position
);
  // ----------------------------------------------------------------------
  // input synchronisers: a change counts once stages two and three agree
  // ----------------------------------------------------------------------
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] raw, s1, s2, s3, clean, next_clean;
  assign raw = {i_step, i_dir, i_resolution_select_0, i_resolution_select_1,
                i_enable_n, i_off_time_set_pin, i_reset_n, i_trip_a, i_trip_b};

  always_comb begin
    next_clean = clean;
    for (int k = 0; k < NSYNC; k++) begin
      if (s2[k] == s3[k]) begin
        next_clean[k] = s3[k];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      clean <= '0;
    end else begin
      s1    <= raw;
      s2    <= s1;
      s3    <= s2;
      clean <= next_clean;
    end
  end

  logic step_s, dir_s, sel0_s, sel1_s, en_n_s, osc_s, rst_n_s, trip_a_s, trip_b_s;
  assign {step_s, dir_s, sel0_s, sel1_s, en_n_s, osc_s, rst_n_s, trip_a_s, trip_b_s} = clean;

  // faults are already on-chip events, one flop is enough to register them
  logic fault;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fault <= 1'b0;
    end else begin
      fault <= i_thermal_shutdown_event | i_overcurrent;
    end
  end

  // ----------------------------------------------------------------------
  // sine table over a quarter turn, eighth-step resolution
  // ----------------------------------------------------------------------
  function automatic logic [3:0] mstc_sine(input logic [2:0] idx, input logic top);
    logic [3:0] r;
    r = 4'h0;
    if (top) begin
      r = 4'hf;
    end else begin
      unique case (idx)
        3'h0: r = 4'h0;
        3'h1: r = 4'h3;
        3'h2: r = 4'h6;
        3'h3: r = 4'h8;
        3'h4: r = 4'hb;
        3'h5: r = 4'hc;
        3'h6: r = 4'he;
        3'h7: r = 4'hf;
      endcase
    end
    return r;
  endfunction : mstc_sine

  // 32 eighth steps per turn; a follows sine, b follows cosine
  function automatic logic [4:0] mstc_entry(input logic [4:0] p);
    logic [2:0] q;
    logic [3:0] m;
    q = p[2:0];
    m = p[3] ? mstc_sine(3'(3'h0 - q), q == 3'h0) : mstc_sine(q, 1'b0);
    return {p[4] ^ 1'b0, m};
  endfunction : mstc_entry

  // ----------------------------------------------------------------------
  // translator
  // ----------------------------------------------------------------------
  logic [4:0] pos, next_pos;
  logic       step_d, next_step_d;
  logic       mixed_a, mixed_b, next_mixed_a, next_mixed_b;
  logic [4:0] ent_a, ent_b, nent_a, nent_b;
  logic [4:0] inc;
  mstc_pkg::mstc_res_e res;
  logic       full_mode, next_full_mode;

  assign ent_a  = mstc_entry(pos);
  assign ent_b  = mstc_entry(5'(pos + 5'h08));
  assign res    = mstc_pkg::mstc_res_e'({sel1_s, sel0_s});

  always_comb begin
    // resolution sampled only here, at the step edge
    unique case (res)
      mstc_pkg::MSTC_RES_FULL:    inc = 5'h08;
      mstc_pkg::MSTC_RES_HALF:    inc = 5'h04;
      mstc_pkg::MSTC_RES_QUARTER: inc = 5'h02;
      mstc_pkg::MSTC_RES_EIGHTH:  inc = 5'h01;
    endcase
  end

  always_comb begin
    next_pos       = pos;
    next_step_d    = step_s;
    next_mixed_a   = mixed_a;
    next_mixed_b   = mixed_b;
    next_full_mode = full_mode;
    nent_a         = ent_a;
    nent_b         = ent_b;
    if (!rst_n_s || fault) begin
      // hold home, step ignored, mixed decay
      next_pos     = mstc_pkg::HOME_POS;
      next_mixed_a = 1'b1;
      next_mixed_b = 1'b1;
      next_step_d  = 1'b1;
      // a stale full-step flag would turn home decay to slow
      next_full_mode = 1'b0;
    end else if (step_s && !step_d) begin
      // rising edge advances by increment in the sampled direction
      next_pos       = dir_s ? 5'(pos + inc) : 5'(pos - inc);
      next_full_mode = (res == mstc_pkg::MSTC_RES_FULL);
      nent_a         = mstc_entry(next_pos);
      nent_b         = mstc_entry(5'(next_pos + 5'h08));
      next_mixed_a   = nent_a[3:0] < ent_a[3:0];
      next_mixed_b   = nent_b[3:0] < ent_b[3:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pos       <= mstc_pkg::HOME_POS;
      step_d    <= 1'b1;
      mixed_a   <= 1'b1;
      mixed_b   <= 1'b1;
      full_mode <= 1'b0;
    end else begin
      pos       <= next_pos;
      step_d    <= next_step_d;
      mixed_a   <= next_mixed_a;
      mixed_b   <= next_mixed_b;
      full_mode <= next_full_mode;
    end
  end

  // ----------------------------------------------------------------------
  // decay policy and bridge loops
  // ----------------------------------------------------------------------
  logic eff_mixed_a, eff_mixed_b, run;
  // pin low forces mixed always; pin high is auto, slow at full step
  assign eff_mixed_a = !osc_s || (mixed_a && !full_mode);
  assign eff_mixed_b = !osc_s || (mixed_b && !full_mode);
  assign run         = rst_n_s && !en_n_s && !fault;

  logic drv_a, fst_a, slw_a, drv_b, fst_b, slw_b;

  mstc_bridge_pwm u_pwm_a (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_run   (run),
    .i_mixed (eff_mixed_a),
    .i_trip  (trip_a_s),
    .o_drive (drv_a),
    .o_fast  (fst_a),
    .o_slow  (slw_a)
  );

  mstc_bridge_pwm u_pwm_b (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_run   (run),
    .i_mixed (eff_mixed_b),
    .i_trip  (trip_b_s),
    .o_drive (drv_b),
    .o_fast  (fst_b),
    .o_slow  (slw_b)
  );

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_level_a  <= 4'h0;
      o_pol_a    <= 1'b0;
      o_level_b  <= 4'h0;
      o_pol_b    <= 1'b0;
      o_mixed_a  <= 1'b1;
      o_mixed_b  <= 1'b1;
      o_position <= mstc_pkg::HOME_POS;
      o_drive_a  <= 1'b0;
      o_fast_a   <= 1'b0;
      o_slow_a   <= 1'b0;
      o_drive_b  <= 1'b0;
      o_fast_b   <= 1'b0;
      o_slow_b   <= 1'b0;
    end else begin
      o_level_a  <= ent_a[3:0];
      o_pol_a    <= ent_a[4];
      o_level_b  <= ent_b[3:0];
      o_pol_b    <= ent_b[4];
      o_mixed_a  <= eff_mixed_a;
      o_mixed_b  <= eff_mixed_b;
      o_position <= pos;
      o_drive_a  <= drv_a;
      o_fast_a   <= fst_a;
      o_slow_a   <= slw_a;
      o_drive_b  <= drv_b;
      o_fast_b   <= fst_b;
      o_slow_b   <= slw_b;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  reset_home_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!rst_n_s || fault) |=> pos == mstc_pkg::HOME_POS && mixed_a && mixed_b)
    else $error("translator not at home in reset");
  reset_off_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
    !run |=> !drv_a && !fst_a && !slw_a && !drv_b && !fst_b && !slw_b)
    else $error("bridges not off");
  step_adv_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
    (rst_n_s && !fault && step_s && !step_d && dir_s) |=> pos == 5'($past(pos) + $past(inc)))
    else $error("step did not advance");
  hold_pos_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
    (rst_n_s && !fault && !(step_s && !step_d)) |=> $stable(pos))
    else $error("position moved without step");
  force_mix_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
    !osc_s |-> eff_mixed_a && eff_mixed_b)
    else $error("grounded pin not mixed");
  full_slow_a : assert property (@(posedge i_clk) disable iff (!i_rstn)
    (osc_s && full_mode) |-> !eff_mixed_a && !eff_mixed_b)
    else $error("full step not slow");
  step_cov_c : cover property (@(posedge i_clk) disable iff (!i_rstn)
    rst_n_s && step_s && !step_d);
  fault_cov_c : cover property (@(posedge i_clk) disable iff (!i_rstn) fault);
endmodule : mstc_top
`default_nettype wire

// file: verif/mstc_host_model.sv
// mstc_host_model: host controller driving step, direction, resolution
// and device reset pins of the translator
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/10ps
`default_nettype none
module mstc_host_model #(
  parameter int PULSE_CYC  = 30,
  parameter int SETTLE_CYC = 25000
) (
  // clock
  input  wire logic i_clk,
  // pins toward the device
  output logic      o_step,
  output logic      o_dir,
  output logic      o_resolution_select_0,
  output logic      o_resolution_select_1,
  output logic      o_reset_n
);
  initial begin
    o_step                = 1'b0;
    o_dir                 = 1'b1;
    o_resolution_select_0 = 1'b1;
    o_resolution_select_1 = 1'b1;
    o_reset_n             = 1'b1;
  end

  task automatic set_mode(input logic [1:0] res, input logic dir);
    @(posedge i_clk);
    o_resolution_select_0 <= res[0];
    o_resolution_select_1 <= res[1];
    o_dir                 <= dir;
  endtask : set_mode

  // both levels stay well above the minimum to cover the input filter
  task automatic step_pulse();
    @(posedge i_clk);
    o_step <= 1'b1;
    repeat (PULSE_CYC) @(posedge i_clk);
    o_step <= 1'b0;
    repeat (PULSE_CYC) @(posedge i_clk);
  endtask : step_pulse

  // after release the host waits before its first step
  task automatic drive_reset(input logic level);
    @(posedge i_clk);
    o_reset_n <= level;
    if (level) begin
      repeat (SETTLE_CYC) @(posedge i_clk);
    end
  endtask : drive_reset
endmodule : mstc_host_model
`default_nettype wire

// file: verif/mstc_top_bench.sv
// mstc_top_bench: self-checking bench for the translator and pwm loops
// assumes the host model drives the translator pins, the bench the rest
`timescale 1ns/10ps
`default_nettype none
module mstc_top_bench;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  localparam int CEIL = 40000;
  logic       clk;
  logic       rstn;
  logic       enable_n;
  logic       off_pin;
  logic       therm_evt;
  logic       ocp;
  logic       trip_a;
  logic       trip_b;
  wire logic  step;
  wire logic  dir;
  wire logic  sel0;
  wire logic  sel1;
  wire logic  reset_n;
  logic [3:0] level_a;
  logic [3:0] level_b;
  logic       pol_a;
  logic       pol_b;
  logic       drive_a;
  logic       fast_a;
  logic       slow_a;
  logic       drive_b;
  logic       fast_b;
  logic       slow_b;
  logic       mixed_a;
  logic       mixed_b;
  logic [4:0] pos;
  int         mismatches;
  int         total_checks;
  int         cycles;

  mstc_host_model #(.PULSE_CYC(30), .SETTLE_CYC(50)) u_host (
    .i_clk(clk), .o_step(step), .o_dir(dir), .o_resolution_select_0(sel0),
    .o_resolution_select_1(sel1), .o_reset_n(reset_n));

  mstc_top u_dut (
    .i_clk(clk), .i_rstn(rstn), .i_step(step), .i_dir(dir),
    .i_resolution_select_0(sel0), .i_resolution_select_1(sel1),
    .i_enable_n(enable_n), .i_off_time_set_pin(off_pin), .i_reset_n(reset_n),
    .i_thermal_shutdown_event(therm_evt), .i_overcurrent(ocp),
    .i_trip_a(trip_a), .i_trip_b(trip_b),
    .o_level_a(level_a), .o_pol_a(pol_a), .o_drive_a(drive_a),
    .o_fast_a(fast_a), .o_slow_a(slow_a),
    .o_level_b(level_b), .o_pol_b(pol_b), .o_drive_b(drive_b),
    .o_fast_b(fast_b), .o_slow_b(slow_b),
    .o_mixed_a(mixed_a), .o_mixed_b(mixed_b), .o_position(pos));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  // sample after the edge's own updates have landed
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : tick

  // resolution is only changed while the translator sits at home
  task automatic go_home(input logic [1:0] res, input logic d);
    u_host.drive_reset(1'b0);
    u_host.set_mode(res, d);
    u_host.drive_reset(1'b1);
    tick(1);
  endtask : go_home

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == CEIL) begin
      mismatches++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic test_home();
    check(16'(pos), 16'h0004, "home position");
    check(16'({mixed_a, mixed_b}), 16'h0003, "home decay");
    check(16'(level_a), 16'(level_b), "home levels");
    check(16'({pol_a, pol_b}), 16'h0000, "home polarity");
    $display("test home done");
  endtask : test_home

  task automatic test_resolution();
    for (int i = 0; i < 4; i++) begin
      go_home(2'(i), 1'b1);
      u_host.step_pulse();
      check(16'(pos), 16'(4 + (8 >> i)), "forward increment");
      u_host.set_mode(2'(i), 1'b0);
      u_host.step_pulse();
      check(16'(pos), 16'h0004, "reverse increment");
    end
    $display("test resolution done");
  endtask : test_resolution

  task automatic test_deferred();
    go_home(mstc_pkg::MSTC_RES_EIGHTH, 1'b1);
    u_host.set_mode(mstc_pkg::MSTC_RES_FULL, 1'b0);
    tick(40);
    check(16'(pos), 16'h0004, "no move without step");
    u_host.step_pulse();
    check(16'(pos), 16'h001c, "new mode at step");
    check(16'({pol_a, pol_b}), 16'h0002, "polarity after reverse");
    $display("test deferred done");
  endtask : test_deferred

  task automatic test_reset_hold();
    go_home(mstc_pkg::MSTC_RES_EIGHTH, 1'b1);
    u_host.drive_reset(1'b0);
    u_host.step_pulse();
    check(16'(pos), 16'h0004, "step during reset");
    check(16'({drive_a, fast_a, slow_a, drive_b, fast_b, slow_b}), 16'h0000, "bridges in reset");
    u_host.drive_reset(1'b1);
    $display("test reset hold done");
  endtask : test_reset_hold

  task automatic test_enable();
    go_home(mstc_pkg::MSTC_RES_QUARTER, 1'b1);
    enable_n <= 1'b1;
    u_host.step_pulse();
    check(16'(pos), 16'h0006, "step while disabled");
    check(16'({drive_a, fast_a, slow_a, drive_b, fast_b, slow_b}), 16'h0000, "bridges disabled");
    enable_n <= 1'b0;
    $display("test enable done");
  endtask : test_enable

  task automatic test_fault();
    for (int f = 0; f < 2; f++) begin
      go_home(mstc_pkg::MSTC_RES_EIGHTH, 1'b1);
      u_host.step_pulse();
      check(16'(pos), 16'h0005, "moved before fault");
      therm_evt <= (f == 0);
      ocp <= (f == 1);
      tick(10);
      check(16'(pos), 16'h0004, "fault returns home");
      therm_evt <= 1'b0;
      ocp <= 1'b0;
      tick(10);
    end
    $display("test fault done");
  endtask : test_fault

  task automatic test_decay(input logic pin, input logic [1:0] res);
    logic [3:0] old_a;
    logic [3:0] old_b;
    off_pin <= pin;
    go_home(res, 1'b1);
    for (int i = 0; i < 8; i++) begin
      old_a = level_a;
      old_b = level_b;
      u_host.step_pulse();
      if (!pin) begin
        check(16'({mixed_a, mixed_b}), 16'h0003, "mixed always");
      end else if (res == mstc_pkg::MSTC_RES_FULL) begin
        check(16'({mixed_a, mixed_b}), 16'h0000, "slow at full");
      end else begin
        check(16'({mixed_a, mixed_b}), 16'({level_a < old_a, level_b < old_b}), "auto decay");
      end
    end
    $display("test decay done");
  endtask : test_decay

  task automatic test_pwm(input logic pin);
    int n;
    int n_fast;
    int n_fast_b;
    int n_off;
    n = 0;
    n_fast = 0;
    n_fast_b = 0;
    n_off = 0;
    off_pin <= pin;
    go_home(mstc_pkg::MSTC_RES_FULL, 1'b1);
    check(16'({mixed_a, mixed_b}), 16'h0003, "mixed after reset");
    if (pin) begin
      u_host.step_pulse();
      check(16'({mixed_a, mixed_b}), 16'h0000, "slow after full step");
    end
    while (drive_a !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    check(16'(drive_a), 16'h0001, "drive phase");
    // trip stays up through the off-time: the next drive phase then lasts only the blanking
    trip_a <= 1'b1;
    trip_b <= 1'b1;
    n = 0;
    while (drive_a === 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    while (drive_a !== 1'b1 && n_off < 1000) begin
      n_fast += int'(fast_a === 1'b1);
      n_fast_b += int'(fast_b === 1'b1);
      n_off += int'(fast_a === 1'b1 || slow_a === 1'b1);
      tick(1);
    end
    n = 0;
    while (drive_a === 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    trip_a <= 1'b0;
    trip_b <= 1'b0;
    check(16'(n_fast), pin ? 16'h0000 : 16'(mstc_pkg::FAST_CYC), "fast part");
    check(16'(n_fast_b), pin ? 16'h0000 : 16'(mstc_pkg::FAST_CYC), "fast part b");
    check(16'(n_off), 16'(mstc_pkg::OFF_CYC), "off-time");
    check(16'(n >= mstc_pkg::BLANK_CYC), 16'h0001, "trip blanked");
    check(16'(n <= mstc_pkg::BLANK_CYC + 2), 16'h0001, "blanking too long");
    $display("test pwm done");
  endtask : test_pwm

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    enable_n = 1'b0;
    off_pin = 1'b1;
    therm_evt = 1'b0;
    ocp = 1'b0;
    trip_a = 1'b0;
    trip_b = 1'b0;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    tick(10);
    test_home();
    test_resolution();
    test_deferred();
    test_reset_hold();
    test_enable();
    test_fault();
    test_decay(1'b1, mstc_pkg::MSTC_RES_EIGHTH);
    test_decay(1'b0, mstc_pkg::MSTC_RES_HALF);
    test_decay(1'b1, mstc_pkg::MSTC_RES_FULL);
    test_pwm(1'b0);
    test_pwm(1'b1);
    end_of_test();
  end
endmodule : mstc_top_bench
`default_nettype wire
